// ===== verilog/vsd_top.sv
// VME slave special decode: location monitors, configuration cycles, first slot detect, register image.
`timescale 1ns/10ps
`include "vsd_regs.svh"
module vsd_top
    import vsd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        vme_as,
    input  wire logic [31:0] vme_addr,
    input  wire logic [5:0]  vme_am,
    input  wire logic        vme_write,
    input  wire logic [31:0] vme_wdata,
    input  wire logic        vme_own,
    output logic             vme_dtack,
    output logic [31:0]      vme_rdata,
    input  wire logic        vme_bg3in_n,
    input  wire logic        vme_iack_n,
    input  wire logic        vme_iackin_n,
    output logic             vme_iack_seen_n,
    output logic             syscon,
    input  wire logic [31:0] por_reg_base,
    input  wire logic        por_reg_en,
    output logic [3:0]       lm_irq,
    output logic             pci_cfg_req,
    output logic [31:0]      pci_cfg_addr,
    output logic             pci_cfg_type1,
    output logic             pci_cfg_write,
    output logic [31:0]      pci_cfg_wdata,
    input  wire logic        pci_cfg_done,
    input  wire logic [31:0] pci_cfg_rdata
);
    vsd_regs_t s_r;
    vsd_regs_t s_nxt;

    logic        lm_hit;
    logic [1:0]  lm_idx;
    logic [31:0] cfg_ad;
    logic        cfg_t1;
    logic        ri_hit;
    logic        si_hit;
    logic        wr_en;
    logic [7:0]  wr_a;
    logic [31:0] wr_d;

    // Only one control and one base register feed all four monitors.
    vsd_lm_decode u_lm (
        .addr      (vme_addr),
        .am        (vme_am),
        .program_data_select       (s_r.mon_pgm),
        .super_sel (s_r.mon_super),
        .space     (s_r.mon_space),
        .base      (s_r.mon_base),
        .hit       (lm_hit),
        .idx       (lm_idx)
    );

    vsd_cfg_addr u_cfg (
        .vaddr  (vme_addr),
        .offset (s_r.si_off),
        .bus_no (s_r.bus_no),
        .ad     (cfg_ad),
        .type1  (cfg_t1)
    );

    assign ri_hit = s_r.ri_en && (vme_addr[31:12] == s_r.ri_base);
    assign si_hit = s_r.si_en && (s_r.si_las == `VSD_LAS_CFG)
                    && (vme_addr[31:12] >= s_r.si_base) && (vme_addr[31:12] < s_r.si_bound);

    function automatic logic [31:0] rd_word(input vsd_regs_t r, input logic [7:0] a);
        logic [31:0] d;
        d = `VSD_RESET_WORD;
        unique case (a)
            `VSD_OFF_MON_CTL: begin
                d[`VSD_MON_EN_BIT]                    = r.mon_en;
                d[`VSD_MON_PGM_LSB +: 2]              = r.mon_pgm;
                d[`VSD_MON_SUPER_LSB +: 2]            = r.mon_super;
                d[`VSD_MON_SPACE_LSB +: 4]            = r.mon_space;
            end
            `VSD_OFF_MON_BASE:   d[`VSD_BASE_LSB +: 20]   = r.mon_base;
            `VSD_OFF_MASTER_CTL: d[`VSD_BUS_NO_LSB +: 8]  = r.bus_no;
            `VSD_OFF_MISC_CONTROL:   d[`VSD_SYSCON_BIT]       = r.syscon;
            `VSD_OFF_SI_CTL: begin
                d[`VSD_IMG_EN_BIT]                    = r.si_en;
                d[`VSD_LAS_LSB +: 2]                  = r.si_las;
            end
            `VSD_OFF_SI_BASE:    d[`VSD_BASE_LSB +: 20]   = r.si_base;
            `VSD_OFF_SI_BOUND:   d[`VSD_BASE_LSB +: 20]   = r.si_bound;
            `VSD_OFF_SI_OFFSET:  d[`VSD_BASE_LSB +: 20]   = r.si_off;
            `VSD_OFF_RI_BASE:    d[`VSD_BASE_LSB +: 20]   = r.ri_base;
            `VSD_OFF_RI_CTL:     d[`VSD_IMG_EN_BIT]       = r.ri_en;
            `VSD_OFF_STATUS: begin
                d[3:0]                                = r.lm_seen;
                d[`VSD_ST_SYSDET_BIT]                 = r.syscon_det;
                d[`VSD_ST_TYPE1_BIT]                  = r.last_t1;
            end
            default:             d = `VSD_RESET_WORD;
        endcase
        return d;
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old_d, input logic [31:0] new_d,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_d & ~m) | (new_d & m);
    endfunction

    always_comb begin
        s_nxt = s_r;

        // Write port: an Avalon write lands at the edge that ends its wait, a VME write in its image cycle.
        wr_en = 1'b0;
        wr_a  = 8'h00;
        wr_d  = 32'h0000_0000;
        if (s_r.st == S_AV_DONE) begin
            wr_en = s_r.av_we;
            wr_a  = s_r.av_addr;
            wr_d  = merge_be(rd_word(s_r, s_r.av_addr), s_r.av_wdata, s_r.av_be);
        end else if (s_r.st == S_VREG) begin
            wr_en = vme_write;
            wr_a  = {vme_addr[7:2], 2'h0};
            wr_d  = vme_wdata;
        end

        if (wr_en) begin
            unique case (wr_a)
                `VSD_OFF_MON_CTL: begin
                    s_nxt.mon_en    = wr_d[`VSD_MON_EN_BIT];
                    s_nxt.mon_pgm   = wr_d[`VSD_MON_PGM_LSB +: 2];
                    s_nxt.mon_super = wr_d[`VSD_MON_SUPER_LSB +: 2];
                    s_nxt.mon_space = wr_d[`VSD_MON_SPACE_LSB +: 4];
                end
                `VSD_OFF_MON_BASE:   s_nxt.mon_base = wr_d[`VSD_BASE_LSB +: 20];
                `VSD_OFF_MASTER_CTL: s_nxt.bus_no   = wr_d[`VSD_BUS_NO_LSB +: 8];
                `VSD_OFF_MISC_CONTROL:   s_nxt.syscon   = wr_d[`VSD_SYSCON_BIT];
                `VSD_OFF_SI_CTL: begin
                    s_nxt.si_en  = wr_d[`VSD_IMG_EN_BIT];
                    s_nxt.si_las = wr_d[`VSD_LAS_LSB +: 2];
                end
                `VSD_OFF_SI_BASE:    s_nxt.si_base  = wr_d[`VSD_BASE_LSB +: 20];
                `VSD_OFF_SI_BOUND:   s_nxt.si_bound = wr_d[`VSD_BASE_LSB +: 20];
                `VSD_OFF_SI_OFFSET:  s_nxt.si_off   = wr_d[`VSD_BASE_LSB +: 20];
                `VSD_OFF_RI_BASE:    s_nxt.ri_base  = wr_d[`VSD_BASE_LSB +: 20];
                `VSD_OFF_RI_CTL:     s_nxt.ri_en    = wr_d[`VSD_IMG_EN_BIT];
                `VSD_OFF_STATUS:     s_nxt.lm_seen  = s_r.lm_seen & ~wr_d[3:0];
                default:             s_nxt.bus_no   = s_r.bus_no;
            endcase
        end

        // The first cycle after reset samples the straps; a software write in that cycle is impossible.
        s_nxt.boot = 1'b0;
        if (s_r.boot) begin
            s_nxt.syscon     = !vme_bg3in_n;
            s_nxt.syscon_det = !vme_bg3in_n;
            s_nxt.ri_base    = por_reg_base[31:12];
            s_nxt.ri_en      = por_reg_en;
        end
        s_nxt.iack_seen_n = s_r.syscon ? vme_iack_n : vme_iackin_n;

        // Monitor interrupts are one-cycle pulses; sticky copies below are set after any clear.
        s_nxt.lm_irq = 4'h0;

        unique case (s_r.st)
            S_IDLE: begin
                s_nxt.waitreq = 1'b1;
                if (vme_as) begin
                    if (ri_hit) begin
                        s_nxt.st = S_VREG;
                    end else if (si_hit) begin
                        s_nxt.cfg_req   = 1'b1;
                        s_nxt.cfg_addr  = cfg_ad;
                        s_nxt.cfg_type1 = cfg_t1;
                        s_nxt.cfg_write = vme_write;
                        s_nxt.cfg_wdata = vme_wdata;
                        s_nxt.last_t1   = cfg_t1;
                        s_nxt.st        = S_CFG;
                    end else if (lm_hit && s_r.mon_en) begin
                        s_nxt.lm_irq[lm_idx]  = 1'b1;
                        s_nxt.lm_seen[lm_idx] = 1'b1;
                        // Write data is dropped here; nothing on this path stores it.
                        s_nxt.st = vme_own ? S_LM_ACK : S_VEND;
                    end else begin
                        s_nxt.st = S_VEND;
                    end
                end else if (avs_read || avs_write) begin
                    s_nxt.av_addr  = avs_address;
                    s_nxt.av_we    = avs_write;
                    s_nxt.av_wdata = avs_writedata;
                    s_nxt.av_be    = avs_byteenable;
                    s_nxt.av_rdata = avs_read ? rd_word(s_r, avs_address) : 32'h0000_0000;
                    s_nxt.waitreq  = 1'b0;
                    s_nxt.st       = S_AV_DONE;
                end
            end
            S_AV_DONE: begin
                s_nxt.waitreq = 1'b1;
                s_nxt.st      = S_IDLE;
            end
            S_VREG: begin
                s_nxt.vme_rdata = rd_word(s_r, {vme_addr[7:2], 2'h0});
                s_nxt.dtack     = 1'b1;
                s_nxt.st        = S_VEND;
            end
            S_LM_ACK: begin
                // Monitor reads carry no data; zero is driven so the bus never floats unknown.
                s_nxt.vme_rdata = 32'h0000_0000;
                s_nxt.dtack     = 1'b1;
                s_nxt.st        = S_VEND;
            end
            S_CFG: begin
                if (pci_cfg_done) begin
                    s_nxt.cfg_req   = 1'b0;
                    s_nxt.vme_rdata = pci_cfg_rdata;
                    s_nxt.dtack     = 1'b1;
                    s_nxt.st        = S_VEND;
                end
            end
            S_VEND: begin
                // Holding here until the strobe drops keeps one VME cycle from being claimed twice.
                if (!vme_as) begin
                    s_nxt.dtack = 1'b0;
                    s_nxt.st    = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_r             <= '0;
            s_r.st          <= S_IDLE;
            s_r.boot        <= 1'b1;
            s_r.waitreq     <= 1'b1;
            s_r.iack_seen_n <= 1'b1;
            s_r.mon_space   <= `VSD_SPACE_A32;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata    = s_r.av_rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign vme_dtack       = s_r.dtack;
    assign vme_rdata       = s_r.vme_rdata;
    assign vme_iack_seen_n = s_r.iack_seen_n;
    assign syscon          = s_r.syscon;
    assign lm_irq          = s_r.lm_irq;
    assign pci_cfg_req     = s_r.cfg_req;
    assign pci_cfg_addr    = s_r.cfg_addr;
    assign pci_cfg_type1   = s_r.cfg_type1;
    assign pci_cfg_write   = s_r.cfg_write;
    assign pci_cfg_wdata   = s_r.cfg_wdata;
endmodule

// ===== verilog/vsd_regs.svh
// Register offsets, field positions, reset values and encodings of the VME slave decode block.
`ifndef VSD_REGS_SVH
`define VSD_REGS_SVH

`define VSD_OFF_MON_CTL      8'h00
`define VSD_OFF_MON_BASE     8'h04
`define VSD_OFF_MASTER_CTL   8'h08
`define VSD_OFF_MISC_CONTROL     8'h0C
`define VSD_OFF_SI_CTL       8'h10
`define VSD_OFF_SI_BASE      8'h14
`define VSD_OFF_SI_BOUND     8'h18
`define VSD_OFF_SI_OFFSET    8'h1C
`define VSD_OFF_RI_BASE      8'h20
`define VSD_OFF_RI_CTL       8'h24
`define VSD_OFF_STATUS       8'h28

`define VSD_MON_EN_BIT       31
`define VSD_MON_PGM_LSB      22
`define VSD_MON_SUPER_LSB    20
`define VSD_MON_SPACE_LSB    16
`define VSD_BASE_LSB         12
`define VSD_BUS_NO_LSB       0
`define VSD_SYSCON_BIT       17
`define VSD_IMG_EN_BIT       31
`define VSD_LAS_LSB          0
`define VSD_ST_SYSDET_BIT    8
`define VSD_ST_TYPE1_BIT     9

`define VSD_SPACE_A16        4'h0
`define VSD_SPACE_A24        4'h1
`define VSD_SPACE_A32        4'h2
`define VSD_AMSP_A16         3'h5
`define VSD_AMSP_A24         3'h7
`define VSD_AMSP_A32         3'h1
`define VSD_AM_DATA          2'h1
`define VSD_AM_PROG          2'h2
`define VSD_LAS_CFG          2'h2
`define VSD_CFG_TYPE1_CODE   2'h1
`define VSD_DEV_LAST         5'h14
`define VSD_RESET_WORD       32'h0000_0000

`endif

// ===== verilog/vsd_pkg.sv
// Types shared by the VME slave decode block.
package vsd_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_AV_DONE,
        S_VREG,
        S_LM_ACK,
        S_CFG,
        S_VEND
    } vsd_state_t;

    typedef struct packed {
        vsd_state_t  st;
        logic        boot;
        logic        mon_en;
        logic [1:0]  mon_pgm;
        logic [1:0]  mon_super;
        logic [3:0]  mon_space;
        logic [19:0] mon_base;
        logic [7:0]  bus_no;
        logic        syscon;
        logic        syscon_det;
        logic        si_en;
        logic [1:0]  si_las;
        logic [19:0] si_base;
        logic [19:0] si_bound;
        logic [19:0] si_off;
        logic        ri_en;
        logic [19:0] ri_base;
        logic [3:0]  lm_seen;
        logic        last_t1;
        logic [7:0]  av_addr;
        logic        av_we;
        logic [31:0] av_wdata;
        logic [3:0]  av_be;
        logic        waitreq;
        logic [31:0] av_rdata;
        logic        dtack;
        logic [31:0] vme_rdata;
        logic [3:0]  lm_irq;
        logic        cfg_req;
        logic [31:0] cfg_addr;
        logic        cfg_type1;
        logic        cfg_write;
        logic [31:0] cfg_wdata;
        logic        iack_seen_n;
    } vsd_regs_t;

endpackage

// ===== verilog/vsd_lm_decode.sv
// Location monitor window and address modifier decode.
`timescale 1ns/10ps
`include "vsd_regs.svh"
module vsd_lm_decode
    import vsd_pkg::*;
(
    input  wire logic [31:0] addr,
    input  wire logic [5:0]  am,
    input  wire logic [1:0]  program_data_select,
    input  wire logic [1:0]  super_sel,
    input  wire logic [3:0]  space,
    input  wire logic [19:0] base,
    output logic             hit,
    output logic [1:0]       idx
);
    logic space_ok;
    logic win_ok;
    logic kind_ok;
    logic priv_ok;

    always_comb begin
        space_ok = 1'b0;
        win_ok   = 1'b0;
        unique case (space)
            `VSD_SPACE_A16: begin
                space_ok = (am[5:3] == `VSD_AMSP_A16);
                win_ok   = (addr[15:12] == base[3:0]);
            end
            `VSD_SPACE_A24: begin
                space_ok = (am[5:3] == `VSD_AMSP_A24);
                win_ok   = (addr[23:12] == base[11:0]);
            end
            `VSD_SPACE_A32: begin
                space_ok = (am[5:3] == `VSD_AMSP_A32);
                win_ok   = (addr[31:12] == base);
            end
            default: begin
                space_ok = 1'b0;
                win_ok   = 1'b0;
            end
        endcase
        // Block transfer codes fall through both tests and are never claimed.
        kind_ok = ((am[1:0] == `VSD_AM_DATA) && program_data_select[0]) || ((am[1:0] == `VSD_AM_PROG) && program_data_select[1]);
        priv_ok = am[2] ? super_sel[1] : super_sel[0];
        hit     = space_ok && win_ok && kind_ok && priv_ok;
        idx     = addr[4:3];
    end
endmodule

// ===== verilog/vsd_cfg_addr.sv
// PCI configuration address builder for Type 0 and Type 1 cycles.
`timescale 1ns/10ps
`include "vsd_regs.svh"
module vsd_cfg_addr
    import vsd_pkg::*;
(
    input  wire logic [31:0] vaddr,
    input  wire logic [19:0] offset,
    input  wire logic [7:0]  bus_no,
    output logic [31:0]      ad,
    output logic             type1
);
    logic [31:0] sum;
    logic [20:0] sel;

    assign sum   = vaddr + {offset, 12'h000};
    assign type1 = (vaddr[23:16] != bus_no);

    genvar i;
    generate
        for (i = 0; i <= 20; i = i + 1) begin : g_idsel
            assign sel[i] = (sum[15:11] == 5'(i));
        end
    endgenerate

    // Device numbers above the last idsel line leave every select line low.
    assign ad = type1 ? {sum[31:2], `VSD_CFG_TYPE1_CODE}
                      : {sel, sum[10:2], 2'h0};
endmodule

// ===== sim/vsd_pci_target.sv
// Behavioural PCI target that completes configuration cycles after a chosen lag.
`timescale 1ns/10ps
module vsd_pci_target (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        req,
    input  wire logic [31:0] addr,
    input  wire logic [1:0]  lag,
    output logic             done,
    output logic [31:0]      rdata
);
    logic [1:0] cnt_r;

    // Outside a completion the data lines walk every cycle, so stale data can never pass as an answer.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_r <= 2'h0;
            done  <= 1'b0;
            rdata <= 32'h5A5A_A5A5;
        end else if (req && !done && cnt_r == lag) begin
            done  <= 1'b1;
            rdata <= ~addr;
        end else begin
            done  <= 1'b0;
            rdata <= {rdata[30:0], ~rdata[31]};
            cnt_r <= (req && !done) ? cnt_r + 2'h1 : 2'h0;
        end
    end
endmodule

// ===== sim/vsd_top_monitor.sv
// Concurrent checks on the ports of the VME slave decode top.
`timescale 1ns/10ps
module vsd_top_monitor (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        vme_as,
    input wire logic [31:0] vme_addr,
    input wire logic        vme_own,
    input wire logic        vme_dtack,
    input wire logic [31:0] vme_rdata,
    input wire logic        vme_iack_n,
    input wire logic        vme_iackin_n,
    input wire logic        vme_iack_seen_n,
    input wire logic        syscon,
    input wire logic [3:0]  lm_irq,
    input wire logic        pci_cfg_req,
    input wire logic [31:0] pci_cfg_addr,
    input wire logic        pci_cfg_type1,
    input wire logic        pci_cfg_done,
    input wire logic [31:0] pci_cfg_rdata
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_irq_pulse: assert property (lm_irq != 4'h0 |-> $onehot(lm_irq) ##1 lm_irq == 4'h0)
        else $error("monitor interrupt not a single one-cycle pulse");
    chk_irq_index: assert property (lm_irq != 4'h0 |-> lm_irq == (4'h1 << $past(vme_addr[4:3])))
        else $error("monitor interrupt does not follow address bits 4:3");
    chk_own_ack: assert property (lm_irq != 4'h0 && vme_own && vme_as |=> vme_dtack)
        else $error("own monitor hit not acknowledged");
    chk_foreign_quiet: assert property (lm_irq != 4'h0 && !vme_own |=> !vme_dtack [*3])
        else $error("foreign monitor hit acknowledged");
    chk_dtack_drop: assert property (vme_dtack && !vme_as |=> !vme_dtack)
        else $error("acknowledge held after strobe dropped");
    chk_cfg_hold: assert property (pci_cfg_req && !pci_cfg_done |=> pci_cfg_req && $stable(pci_cfg_addr))
        else $error("configuration request dropped or address moved");
    chk_cfg_end: assert property (pci_cfg_req && pci_cfg_done |=>
        !pci_cfg_req && vme_dtack && vme_rdata == $past(pci_cfg_rdata))
        else $error("configuration completion not passed to the bus");
    chk_cfg_code: assert property (pci_cfg_req |-> pci_cfg_addr[1:0] == {1'b0, pci_cfg_type1})
        else $error("configuration address type code wrong");
    chk_cfg_onehot: assert property (pci_cfg_req && !pci_cfg_type1 |-> $onehot(pci_cfg_addr[31:11]))
        else $error("type 0 device select not one-hot");
    chk_iack_route: assert property ($past(rstn) |->
        vme_iack_seen_n == ($past(syscon) ? $past(vme_iack_n) : $past(vme_iackin_n)))
        else $error("acknowledge input routing wrong");

    cov_own_hit: cover property (lm_irq != 4'h0 && vme_own ##1 vme_dtack);
    cov_cfg_type0: cover property (pci_cfg_req && !pci_cfg_type1 && pci_cfg_done);
    cov_cfg_type1: cover property (pci_cfg_req && pci_cfg_type1 && pci_cfg_done);
endmodule

bind vsd_top vsd_top_monitor chk_u (.clk_sys(clk_sys), .rstn(rstn), .vme_as(vme_as), .vme_addr(vme_addr),
    .vme_own(vme_own), .vme_dtack(vme_dtack), .vme_rdata(vme_rdata), .vme_iack_n(vme_iack_n),
    .vme_iackin_n(vme_iackin_n), .vme_iack_seen_n(vme_iack_seen_n), .syscon(syscon), .lm_irq(lm_irq),
    .pci_cfg_req(pci_cfg_req), .pci_cfg_addr(pci_cfg_addr), .pci_cfg_type1(pci_cfg_type1),
    .pci_cfg_done(pci_cfg_done), .pci_cfg_rdata(pci_cfg_rdata));

// ===== sim/vsd_slave_decode_tb_top.sv
// Self-checking bench for the VME slave decode block.
`timescale 1ns/10ps
`include "vsd_regs.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module vme_slave_special_decode_tb_top;
    localparam logic [31:0] POR_BASE = 32'h00C0_0000;
    logic        clk_sys = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, vme_addr = 32'h0, vme_wdata = 32'h0, a, q, ca;
    logic        vme_as = 1'b0, vme_write = 1'b0, vme_own = 1'b0, vme_bg3in_n = 1'b1;
    logic        vme_iack_n = 1'b1, vme_iackin_n = 1'b1, ack, own, hit;
    logic [5:0]  vme_am = 6'h00;
    logic [1:0]  lag = 2'h0;
    logic [19:0] base, off;
    logic [7:0]  bn;
    logic [3:0]  irq;
    logic [31:0] avs_readdata, vme_rdata, pci_cfg_addr, pci_cfg_wdata, pci_cfg_rdata;
    logic        avs_waitrequest, vme_dtack, vme_iack_seen_n, syscon, pci_cfg_req, pci_cfg_type1;
    logic        pci_cfg_write, pci_cfg_done;
    logic [3:0]  lm_irq;
    int          errors = 0, checks = 0;

    always #2 clk_sys = ~clk_sys;

    vsd_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vme_as(vme_as), .vme_addr(vme_addr),
        .vme_am(vme_am), .vme_write(vme_write), .vme_wdata(vme_wdata), .vme_own(vme_own), .vme_dtack(vme_dtack),
        .vme_rdata(vme_rdata), .vme_bg3in_n(vme_bg3in_n), .vme_iack_n(vme_iack_n), .vme_iackin_n(vme_iackin_n),
        .vme_iack_seen_n(vme_iack_seen_n), .syscon(syscon), .por_reg_base(POR_BASE), .por_reg_en(1'b1),
        .lm_irq(lm_irq), .pci_cfg_req(pci_cfg_req), .pci_cfg_addr(pci_cfg_addr), .pci_cfg_type1(pci_cfg_type1),
        .pci_cfg_write(pci_cfg_write), .pci_cfg_wdata(pci_cfg_wdata), .pci_cfg_done(pci_cfg_done),
        .pci_cfg_rdata(pci_cfg_rdata));

    vsd_pci_target pci_u (.clk_sys(clk_sys), .rstn(rstn), .req(pci_cfg_req), .addr(pci_cfg_addr), .lag(lag),
        .done(pci_cfg_done), .rdata(pci_cfg_rdata));

    task automatic close_out;
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic do_reset(input logic bg);
        rstn <= 1'b0;
        vme_bg3in_n <= bg;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    // The request stands until waitrequest is seen low; one edge passes after release.
    task automatic av(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rd);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask

    // A monitor hit by a foreign master gets no acknowledge, so the master gives up after twelve edges.
    task automatic vme(input logic ow, input logic [31:0] ad, input logic [5:0] am, input logic wr,
                       output logic ak, output logic [31:0] rd, output logic [3:0] ir, output logic [31:0] cf);
        int n;
        ak = 1'b0;
        ir = 4'h0;
        rd = 32'h0;
        cf = 32'h0;
        vme_as <= 1'b1;
        vme_addr <= ad;
        vme_am <= am;
        vme_own <= ow;
        vme_write <= wr;
        vme_wdata <= $urandom;
        for (n = 0; n < 12 && !ak; n++) begin
            @(posedge clk_sys);
            ir = ir | lm_irq;
            if (pci_cfg_req === 1'b1) cf = pci_cfg_addr;
            if (pci_cfg_req === 1'b1) `CHK("cfg wr", {vme_write, vme_wdata}, {pci_cfg_write, pci_cfg_wdata})
            if (vme_dtack === 1'b1) begin
                ak = 1'b1;
                rd = vme_rdata;
            end
        end
        vme_as <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    function automatic logic [5:0] am_of(input int sp, input int v);
        am_of[5:3] = (sp == 0) ? 3'b101 : (sp == 1) ? 3'b111 : 3'b001;
        am_of[2:0] = (v == 1) ? 3'b101 : (v == 2) ? 3'b010 : (v == 3) ? 3'b011 : (v == 4) ? 3'b000 : 3'b001;
    endfunction

    function automatic logic [31:0] reset_val(input logic [7:0] ad);
        case (ad)
            `VSD_OFF_MON_CTL, `VSD_OFF_MISC_CONTROL: reset_val = 32'h0002_0000;
            `VSD_OFF_RI_BASE: reset_val = POR_BASE & 32'hFFFF_F000;
            `VSD_OFF_RI_CTL:  reset_val = 32'h8000_0000;
            `VSD_OFF_STATUS:  reset_val = 32'h0000_0100;
            default:          reset_val = 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] cfg_exp(input logic [31:0] ad, input logic [19:0] of, input logic [7:0] b);
        logic [31:0] s;
        s = ad + {of, 12'h000};
        if (ad[23:16] == b) cfg_exp = {21'h1 << s[15:11], s[10:2], 2'b00};
        else cfg_exp = {s[31:2], 2'b01};
    endfunction

    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        void'($urandom(32'h7FB7));
        do_reset(1'b1);
        `CHK("syscon", 1'b0, syscon)
        do_reset(1'b0);
        `CHK("syscon", 1'b1, syscon)
        for (int r = 0; r <= 8'h2C; r += 4) begin
            av(1'b0, 8'(r), 32'h0, q);
            `CHK("reset value", reset_val(8'(r)), q)
        end
        av(1'b1, 8'hFC, $urandom, q);
        av(1'b0, 8'hFC, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        for (int r = `VSD_OFF_SI_BASE; r <= `VSD_OFF_SI_OFFSET; r += 4) begin
            a = $urandom;
            av(1'b1, 8'(r), a, q);
            av(1'b0, 8'(r), 32'h0, q);
            `CHK("image field", a & 32'hFFFF_F000, q)
        end
        vme_iack_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("iack seen", 1'b0, vme_iack_seen_n)
        av(1'b1, `VSD_OFF_MISC_CONTROL, 32'h0, q);
        repeat (2) @(posedge clk_sys);
        `CHK("syscon", 1'b0, syscon)
        `CHK("iack seen", 1'b1, vme_iack_seen_n)
        av(1'b1, `VSD_OFF_MISC_CONTROL, 32'h1 << `VSD_SYSCON_BIT, q);
        `CHK("syscon", 1'b1, syscon)
        for (int sp = 0; sp < 3; sp++) begin
            base = {1'b1, 19'($urandom)};
            av(1'b1, `VSD_OFF_MON_BASE, {base, 12'h000}, q);
            av(1'b1, `VSD_OFF_MON_CTL, 32'h8050_0000 | (sp << `VSD_MON_SPACE_LSB), q);
            for (int v = 0; v < 6; v++) begin
                a = $urandom;
                a[31] = 1'b1;
                if (sp == 2) a[31:12] = base;
                else if (sp == 1) a[23:12] = base[11:0];
                else a[15:12] = base[3:0];
                if (v == 5) a[12] = ~a[12];
                own = 1'($urandom);
                hit = (v == 0);
                vme(own, a, am_of(sp, v), 1'($urandom), ack, q, irq, ca);
                `CHK("lm_irq", hit ? 4'h1 << a[4:3] : 4'h0, irq)
                `CHK("lm ack", hit & own, ack)
            end
        end
        av(1'b1, `VSD_OFF_MON_CTL, 32'h0052_0000, q);
        vme(1'b1, {base, 12'h018}, 6'h09, 1'b0, ack, q, irq, ca);
        `CHK("disabled lm_irq", 4'h0, irq)
        av(1'b0, `VSD_OFF_MON_BASE, 32'h0, q);
        `CHK("monitor base", {base, 12'h000}, q)
        vme(1'b1, POR_BASE | 32'h4, 6'h09, 1'b0, ack, q, irq, ca);
        `CHK("register image", {1'b1, base, 12'h000}, {ack, q})
        bn = 8'($urandom);
        off = {16'($urandom), 4'h0};
        av(1'b1, `VSD_OFF_MASTER_CTL, {24'h0, bn}, q);
        av(1'b1, `VSD_OFF_SI_CTL, 32'h8000_0002, q);
        av(1'b1, `VSD_OFF_SI_BASE, 32'h4000_0000, q);
        av(1'b1, `VSD_OFF_SI_BOUND, 32'h5000_0000, q);
        av(1'b1, `VSD_OFF_SI_OFFSET, {off, 12'h000}, q);
        for (int i = 0; i < 10; i++) begin
            a = {4'h4, 28'($urandom)};
            if (i % 2 == 0) begin
                a[23:16] = bn;
                a[15:11] = (i == 0) ? 5'd0 : (i == 2) ? 5'd20 : 5'($urandom_range(0, 20));
            end else a[23:16] = bn ^ 8'($urandom_range(1, 255));
            lag <= 2'($urandom);
            vme(1'b0, a, 6'h09, 1'($urandom), ack, q, irq, ca);
            `CHK("cfg ack", 1'b1, ack)
            `CHK("cfg address", cfg_exp(a, off, bn), ca)
            `CHK("cfg data", ~cfg_exp(a, off, bn), q)
        end
        close_out();
    end
endmodule
